// >>> hdl/hmws_consts.svh
// constants of the hall measure wake sequencer: offsets, fields, timing
// assumes a 100 MHz core clock and a 32-bit classic wishbone slave port
// Summary of operation
// - idle, continuous, wake-up sleep, single pass modes
// - periodic modes repeat passes over enabled items
// - active from oversampling/filter, gap from standby
// - single mode runs one pass then idles
// - field item count equals enabled axes
// - temperature adds 69 + 96*2^osr microseconds
// - continuous: axis terms, temperature, 108 us overhead
// - single mode uses 328 us overhead instead
// - filter depth field is plain binary exponent
// - wake sources: field threshold and angle limit
// - temperature never causes a wake
// - axis-temperature format selects threshold wake
// - angle format selects angle wake
// - raise interrupt when field moves past threshold
// - one data read drops the interrupt while the done bit is masked
// - interrupt rises again on later excursion
// - angle above limit raises interrupt
`ifndef HMWS_CONSTS_SVH
`define HMWS_CONSTS_SVH
// ===========================================================
// register map, byte addresses
`define HMWS_ADR_CTRL 8'h00
`define HMWS_ADR_ITEMS 8'h04
`define HMWS_ADR_TIMING 8'h08
`define HMWS_ADR_THRESH 8'h0c
`define HMWS_ADR_ALIMIT 8'h10
`define HMWS_ADR_STATUS 8'h14
`define HMWS_ADR_MASK 8'h18
`define HMWS_ADR_STATE 8'h1c
`define HMWS_ADR_DATX 8'h20
`define HMWS_ADR_DATY 8'h24
`define HMWS_ADR_DATZ 8'h28
`define HMWS_ADR_DATA 8'h2c
// writable bits and reset values
`define HMWS_MSK_CTRL 32'h0000000f
`define HMWS_MSK_ITEMS 32'h0000000f
`define HMWS_MSK_TIMING 32'h00ff0777
`define HMWS_MSK_IRQ 32'h00000007
`define HMWS_MSK_ALIMIT 32'h0000ffff
`define HMWS_RST_WORD 32'h00000000
// mode field codes
`define HMWS_MODE_IDLE 2'h0
`define HMWS_MODE_CONT 2'h1
`define HMWS_MODE_WAKE 2'h2
`define HMWS_MODE_SINGLE 2'h3
// status bits
`define HMWS_ST_FIELD 0
`define HMWS_ST_ANGLE 1
`define HMWS_ST_DONE 2
// timing in microseconds
`define HMWS_CLK_MHZ 100
`define HMWS_US_CYCLES (`HMWS_CLK_MHZ)
`define HMWS_ITEM_US 24'h000045
`define HMWS_AXIS_STEP_US 24'h000020
`define HMWS_TEMP_STEP_US 24'h000060
`define HMWS_OVH_CONT_US 24'h00006c
`define HMWS_OVH_SINGLE_US 24'h000148
`define HMWS_STANDBY_STEP_US 16'h0064
`endif

// >>> hdl/hmws_pkg.sv
// types of the hall measure wake sequencer
// assumes hmws_consts.svh provides the numeric constants
package hmws_pkg;
  // ===========================================================
  // sequencer phases
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_STANDBY} hmws_state_e;
  // decoded configuration
  typedef struct packed {
    logic [1:0] mode;
    logic angle_read_format;
    logic ref_update;
    logic [3:0] items;
    logic [2:0] field_oversample_exp;
    logic [2:0] temperature_oversample_exp;
    logic [2:0] filter_depth_exp;
    logic [7:0] standby_interval_setting;
  } hmws_cfg_s;
  // one set of converter results
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] angle;
  } hmws_sample_s;
endpackage

// >>> hdl/hmws_top.sv
// hall measure wake sequencer: mode control, pass timing, wake logic
// assumes converter results on the field/angle inputs are valid
// whenever a pass ends; registers reached over classic wishbone
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "hmws_consts.svh"
module hmws_top
(
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [15:0] I_FIELD_X,
  input wire logic [15:0] I_FIELD_Y,
  input wire logic [15:0] I_FIELD_Z,
  input wire logic [15:0] I_ANGLE,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_INT,
  output logic O_CONV_ACTIVE
);
  // ===========================================================
  // register state
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] items_ff, nxt_items;
  logic [31:0] timing_ff, nxt_timing;
  logic [31:0] thresh_ff, nxt_thresh;
  logic [31:0] alimit_ff, nxt_alimit;
  logic [31:0] mask_ff, nxt_mask;
  logic [31:0] status_ff, nxt_status;
  logic [31:0] rdat_ff, nxt_rdat;
  logic ack_ff, nxt_ack;
  logic int_ff, nxt_int;
  // sequencer state
  hmws_pkg::hmws_state_e state_ff, nxt_state;
  logic [6:0] div_ff, nxt_div;
  logic [23:0] remain_ff, nxt_remain;
  logic active_ff, nxt_active;
  logic ref_valid_ff, nxt_ref_valid;
  hmws_pkg::hmws_sample_s ref_ff, nxt_ref;
  hmws_pkg::hmws_sample_s data_ff, nxt_data;

  // ===========================================================
  // bus decode
  logic [31:0] wmask;
  logic req;
  logic wr;
  logic rd;
  logic pass_end;
  logic single_end;
  logic [2:0] irq_set;
  hmws_pkg::hmws_cfg_s cfg;
  hmws_pkg::hmws_sample_s cur;

  // one cycle per request; ack low in the cycle after it was given
  assign req = I_WB_CYC & I_WB_STB & ~ack_ff;
  assign wr = req & I_WB_WE;
  assign rd = req & ~I_WB_WE;

  // byte lane enables widened to a bit mask
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl = gl + 1)
    begin : g_lane
      assign wmask[gl*8 +: 8] = {8{I_WB_SEL[gl]}};
    end
  endgenerate

  // configuration view of the control words
  assign cfg.mode = ctrl_ff[1:0];
  assign cfg.angle_read_format = ctrl_ff[2];
  assign cfg.ref_update = ctrl_ff[3];
  assign cfg.items = items_ff[3:0];
  assign cfg.field_oversample_exp = timing_ff[2:0];
  assign cfg.temperature_oversample_exp = timing_ff[6:4];
  assign cfg.filter_depth_exp = timing_ff[10:8];
  assign cfg.standby_interval_setting = timing_ff[23:16];
  assign cur = {I_FIELD_X, I_FIELD_Y, I_FIELD_Z, I_ANGLE};

  // ===========================================================
  // pass duration in microseconds
  logic [23:0] step_us;
  logic [23:0] axis_us;
  logic [23:0] temp_us;
  logic [23:0] pass_us;
  logic [23:0] standby_us;
  logic [23:0] axes_us;

  // 32*2^osr*(2+2^depth) done as two shifts, no multiplier needed
  assign step_us = `HMWS_AXIS_STEP_US << cfg.field_oversample_exp;
  assign axis_us = `HMWS_ITEM_US + (step_us << 1)
                   + (step_us << cfg.filter_depth_exp);
  assign temp_us = cfg.items[3] ? (`HMWS_ITEM_US + (`HMWS_TEMP_STEP_US
                   << cfg.temperature_oversample_exp)) : 24'h000000;

  // one axis term per enabled field axis
  always_comb
  begin
    axes_us = 24'h000000;
    for (int i = 0; i < 3; i++)
    begin
      if (cfg.items[i])
      begin
        axes_us = axes_us + axis_us;
      end
    end
  end

  // single mode pays a longer fixed overhead
  assign pass_us = axes_us + temp_us + ((cfg.mode == `HMWS_MODE_SINGLE)
                   ? `HMWS_OVH_SINGLE_US : `HMWS_OVH_CONT_US);
  assign standby_us = 24'(cfg.standby_interval_setting
                      * `HMWS_STANDBY_STEP_US);

  // ===========================================================
  // wake comparison, one comparator per axis
  logic [2:0] exceed;
  logic [15:0] axis_thr [3];
  logic [15:0] axis_cur [3];
  logic [15:0] axis_ref [3];
  assign axis_thr[0] = thresh_ff[15:0];
  assign axis_thr[1] = thresh_ff[15:0];
  assign axis_thr[2] = thresh_ff[31:16];
  assign axis_cur[0] = cur.x;
  assign axis_cur[1] = cur.y;
  assign axis_cur[2] = cur.z;
  assign axis_ref[0] = ref_ff.x;
  assign axis_ref[1] = ref_ff.y;
  assign axis_ref[2] = ref_ff.z;

  genvar ga;
  generate
    for (ga = 0; ga < 3; ga = ga + 1)
    begin : g_axis
      logic signed [16:0] diff;
      logic [16:0] mag;
      // signed fields; 17 bits so the difference never wraps
      assign diff = 17'($signed(axis_cur[ga])) - 17'($signed(axis_ref[ga]));
      assign mag = diff[16] ? 17'(-diff) : diff;
      // temperature bit 3 has no comparator at all
      assign exceed[ga] = cfg.items[ga]
                          & (mag > {1'b0, axis_thr[ga]});
    end
  endgenerate

  // ===========================================================
  // sequencer next state
  logic trig_field;
  logic trig_angle;
  logic wake_mode;
  assign wake_mode = (cfg.mode == `HMWS_MODE_WAKE);
  assign trig_field = pass_end & wake_mode & ~cfg.angle_read_format
                      & ref_valid_ff & (|exceed);
  assign trig_angle = pass_end & wake_mode & cfg.angle_read_format
                      & (cur.angle > alimit_ff[15:0]);
  assign irq_set = {pass_end, trig_angle, trig_field};
  assign single_end = pass_end & (cfg.mode == `HMWS_MODE_SINGLE);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_remain = remain_ff;
    nxt_ref_valid = ref_valid_ff;
    nxt_ref = ref_ff;
    nxt_data = data_ff;
    pass_end = 1'b0;
    // microsecond prescaler runs only while timing
    if (state_ff == hmws_pkg::ST_IDLE ||
        div_ff == 7'(`HMWS_US_CYCLES - 1))
    begin
      nxt_div = 7'h00;
    end
    else
    begin
      nxt_div = div_ff + 7'h01;
    end
    case (state_ff)
      hmws_pkg::ST_IDLE:
      begin
        // a fresh start forgets the old reference
        if (cfg.mode != `HMWS_MODE_IDLE)
        begin
          nxt_state = hmws_pkg::ST_ACTIVE;
          nxt_remain = pass_us;
          nxt_ref_valid = 1'b0;
        end
      end
      hmws_pkg::ST_ACTIVE:
      begin
        if (div_ff == 7'(`HMWS_US_CYCLES - 1))
        begin
          nxt_remain = remain_ff - 24'h000001;
          if (remain_ff == 24'h000001)
          begin
            pass_end = 1'b1;
            nxt_data = cur;
            if (cfg.mode == `HMWS_MODE_SINGLE)
            begin
              nxt_state = hmws_pkg::ST_IDLE;
            end
            else if (standby_us == 24'h000000)
            begin
              nxt_remain = pass_us;
            end
            else
            begin
              nxt_state = hmws_pkg::ST_STANDBY;
              nxt_remain = standby_us;
            end
          end
        end
      end
      hmws_pkg::ST_STANDBY:
      begin
        // no conversion in the gap; low power phase
        if (div_ff == 7'(`HMWS_US_CYCLES - 1))
        begin
          nxt_remain = remain_ff - 24'h000001;
          if (remain_ff == 24'h000001)
          begin
            nxt_state = hmws_pkg::ST_ACTIVE;
            nxt_remain = pass_us;
          end
        end
      end
      default:
      begin
        nxt_state = hmws_pkg::ST_IDLE;
      end
    endcase
    // first pass sets the reference; later ones may move it
    if (pass_end & wake_mode & ~cfg.angle_read_format)
    begin
      if (!ref_valid_ff)
      begin
        nxt_ref = cur;
        nxt_ref_valid = 1'b1;
      end
      else if (trig_field & cfg.ref_update)
      begin
        nxt_ref = cur;
      end
    end
    // software idling aborts any phase at once
    if (cfg.mode == `HMWS_MODE_IDLE)
    begin
      nxt_state = hmws_pkg::ST_IDLE;
      nxt_remain = 24'h000000;
    end
  end

  // active indication follows the phase register
  assign nxt_active = (nxt_state == hmws_pkg::ST_ACTIVE);

  // sequencer registers
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST)
    begin
      state_ff <= hmws_pkg::ST_IDLE;
      div_ff <= 7'h00;
      remain_ff <= 24'h000000;
      active_ff <= 1'b0;
      ref_valid_ff <= 1'b0;
      ref_ff <= '0;
      data_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      remain_ff <= nxt_remain;
      active_ff <= nxt_active;
      ref_valid_ff <= nxt_ref_valid;
      ref_ff <= nxt_ref;
      data_ff <= nxt_data;
    end
  end

  // ===========================================================
  // register file next values
  logic data_rd;
  assign data_rd = rd & (I_WB_ADR == `HMWS_ADR_DATX ||
                         I_WB_ADR == `HMWS_ADR_DATY ||
                         I_WB_ADR == `HMWS_ADR_DATZ ||
                         I_WB_ADR == `HMWS_ADR_DATA);

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_items = items_ff;
    nxt_timing = timing_ff;
    nxt_thresh = thresh_ff;
    nxt_alimit = alimit_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    nxt_rdat = rdat_ff;
    nxt_ack = req;
    // single pass hands the mode field back to idle
    if (single_end)
    begin
      nxt_ctrl[1:0] = `HMWS_MODE_IDLE;
    end
    if (wr)
    begin
      case (I_WB_ADR)
        `HMWS_ADR_CTRL: nxt_ctrl = ((ctrl_ff & ~wmask) |
          (I_WB_DAT & wmask)) & `HMWS_MSK_CTRL;
        `HMWS_ADR_ITEMS: nxt_items = ((items_ff & ~wmask) |
          (I_WB_DAT & wmask)) & `HMWS_MSK_ITEMS;
        `HMWS_ADR_TIMING: nxt_timing = ((timing_ff & ~wmask) |
          (I_WB_DAT & wmask)) & `HMWS_MSK_TIMING;
        `HMWS_ADR_THRESH: nxt_thresh = (thresh_ff & ~wmask) |
          (I_WB_DAT & wmask);
        `HMWS_ADR_ALIMIT: nxt_alimit = ((alimit_ff & ~wmask) |
          (I_WB_DAT & wmask)) & `HMWS_MSK_ALIMIT;
        `HMWS_ADR_MASK: nxt_mask = ((mask_ff & ~wmask) |
          (I_WB_DAT & wmask)) & `HMWS_MSK_IRQ;
        default: nxt_ctrl = nxt_ctrl; // unmapped writes are dropped
      endcase
    end
    // read of status clears all; data read clears wake bits
    if (rd && I_WB_ADR == `HMWS_ADR_STATUS)
    begin
      nxt_status = 32'h00000000;
    end
    else if (data_rd)
    begin
      nxt_status[`HMWS_ST_FIELD] = 1'b0;
      nxt_status[`HMWS_ST_ANGLE] = 1'b0;
    end
    // events set last, so a set beats a same-cycle clear
    nxt_status[2:0] = nxt_status[2:0] | irq_set;
    if (rd)
    begin
      case (I_WB_ADR)
        `HMWS_ADR_CTRL: nxt_rdat = ctrl_ff;
        `HMWS_ADR_ITEMS: nxt_rdat = items_ff;
        `HMWS_ADR_TIMING: nxt_rdat = timing_ff;
        `HMWS_ADR_THRESH: nxt_rdat = thresh_ff;
        `HMWS_ADR_ALIMIT: nxt_rdat = alimit_ff;
        `HMWS_ADR_STATUS: nxt_rdat = status_ff;
        `HMWS_ADR_MASK: nxt_rdat = mask_ff;
        `HMWS_ADR_STATE: nxt_rdat = {29'h0, ref_valid_ff, state_ff};
        `HMWS_ADR_DATX: nxt_rdat = {16'h0000, data_ff.x};
        `HMWS_ADR_DATY: nxt_rdat = {16'h0000, data_ff.y};
        `HMWS_ADR_DATZ: nxt_rdat = {16'h0000, data_ff.z};
        `HMWS_ADR_DATA: nxt_rdat = {16'h0000, data_ff.angle};
        default: nxt_rdat = 32'h00000000;
      endcase
    end
    // level interrupt from the next status, so it lands with the bit
    nxt_int = |(nxt_status & nxt_mask);
  end

  // register file flops
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST)
    begin
      ctrl_ff <= `HMWS_RST_WORD;
      items_ff <= `HMWS_RST_WORD;
      timing_ff <= `HMWS_RST_WORD;
      thresh_ff <= `HMWS_RST_WORD;
      alimit_ff <= `HMWS_RST_WORD;
      mask_ff <= `HMWS_RST_WORD;
      status_ff <= `HMWS_RST_WORD;
      rdat_ff <= `HMWS_RST_WORD;
      ack_ff <= 1'b0;
      int_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      items_ff <= nxt_items;
      timing_ff <= nxt_timing;
      thresh_ff <= nxt_thresh;
      alimit_ff <= nxt_alimit;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      rdat_ff <= nxt_rdat;
      ack_ff <= nxt_ack;
      int_ff <= nxt_int;
    end
  end

  // ===========================================================
  // outputs straight from flops
  assign O_WB_DAT = rdat_ff;
  assign O_WB_ACK = ack_ff;
  assign O_INT = int_ff;
  assign O_CONV_ACTIVE = active_ff;

endmodule // hmws_top

// >>> test/hmws_field_src.sv
// converter front-end model feeding field and angle results
// assumes the bench sets targets; results only meaningful in a pass
`timescale 1ns/1ps
module hmws_field_src
(
  input wire logic i_clk,
  input wire logic i_conv,
  input wire hmws_pkg::hmws_sample_s i_target,
  output hmws_pkg::hmws_sample_s o_sample
);
  // ===========================================================
  // results register
  hmws_pkg::hmws_sample_s last_ff = '0;
  // outside a pass invert every cycle, so a stale copy shows only every other cycle
  always_ff @(posedge i_clk)
  begin
    if (i_conv)
      last_ff <= i_target;
    else
      last_ff <= ~last_ff;
  end
  assign o_sample = last_ff;
endmodule // hmws_field_src

// >>> test/hmws_top_props.sv
// checker for the hall measure wake sequencer, top ports only
// assumes bound into hmws_top; one clock, synchronous low reset
`timescale 1ns/1ps
`include "hmws_consts.svh"
module hmws_top_props
(
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_INT,
  input wire logic O_CONV_ACTIVE
);
  // ===========================================================
  // request decode and a copy of the interrupt mask
  logic req;
  logic ctrl_wr;
  logic dat_rd;
  logic [2:0] mask_ff;
  logic [2:0] nxt_mask;
  assign req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign ctrl_wr = req & I_WB_WE & I_WB_SEL[0]
    & (I_WB_ADR == `HMWS_ADR_CTRL);
  assign dat_rd = req & ~I_WB_WE & (I_WB_ADR inside {`HMWS_ADR_DATX,
    `HMWS_ADR_DATY, `HMWS_ADR_DATZ, `HMWS_ADR_DATA});
  // mirror kept so interrupt checks know which bits may drive it
  always_comb
  begin
    nxt_mask = mask_ff;
    if (req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == `HMWS_ADR_MASK)
      nxt_mask = I_WB_DAT[2:0];
  end
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST)
      mask_ff <= 3'h0;
    else
      mask_ff <= nxt_mask;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  // ===========================================================
  // bus handshake
  property p_ack_resp;
    req |=> O_WB_ACK;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not acknowledged next cycle");
  property p_ack_pulse;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_unmapped;
    req && !I_WB_WE && I_WB_ADR == 8'h40 |=> O_WB_DAT == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_reset_quiet;
    $rose(I_NRST) |-> !O_WB_ACK && !O_INT && !O_CONV_ACTIVE
      && O_WB_DAT == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  // ===========================================================
  // sequencer start and stop
  property p_start;
    ctrl_wr && I_WB_DAT[1:0] != `HMWS_MODE_IDLE && !O_CONV_ACTIVE
      |-> ##[2:3] O_CONV_ACTIVE;
  endproperty
  a_start: assert property (p_start)
    else $error("mode start did not begin a pass");
  property p_abort;
    ctrl_wr && I_WB_DAT[1:0] == `HMWS_MODE_IDLE
      |-> ##[2:3] !O_CONV_ACTIVE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("idle write did not stop the pass");
  // ===========================================================
  // interrupt
  property p_data_clr;
    dat_rd && !mask_ff[2] |-> ##2 !O_INT;
  endproperty
  a_data_clr: assert property (p_data_clr)
    else $error("data read left interrupt high");
  property p_stat_clr;
    req && !I_WB_WE && I_WB_ADR == `HMWS_ADR_STATUS |-> ##2 !O_INT;
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("status read left interrupt high");
  property p_int_mask;
    O_INT |-> mask_ff != 3'h0 || $past(mask_ff) != 3'h0;
  endproperty
  a_int_mask: assert property (p_int_mask)
    else $error("interrupt with all sources masked");
  c_pass: cover property ($rose(O_CONV_ACTIVE));
  c_int: cover property ($rose(O_INT));
  c_dat_rd: cover property (dat_rd ##1 O_WB_ACK);
endmodule // hmws_top_props

bind hmws_top hmws_top_props u_props
(
  .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_INT(O_INT), .O_CONV_ACTIVE(O_CONV_ACTIVE)
);

// >>> test/testbench.sv
// self-checking bench for the hall measure wake sequencer
// assumes hmws_top, hmws_field_src and the bound checker are compiled
`timescale 1ns/1ps
`include "hmws_consts.svh"
module testbench;
  // ===========================================================
  // signals
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] rd;
  } hmws_row_s;
  localparam hmws_row_s rows [7] = '{
    '{`HMWS_ADR_CTRL, 32'hfffffffc, 32'h0000000c},
    '{`HMWS_ADR_ITEMS, 32'hffffffff, 32'h0000000f},
    '{`HMWS_ADR_TIMING, 32'hffffffff, 32'h00ff0777},
    '{`HMWS_ADR_THRESH, 32'hffffffff, 32'hffffffff},
    '{`HMWS_ADR_ALIMIT, 32'hffffffff, 32'h0000ffff},
    '{`HMWS_ADR_MASK, 32'hffffffff, 32'h00000007},
    '{8'h40, 32'hffffffff, 32'h00000000}};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rdv;
  logic ack;
  logic irq;
  logic conv;
  hmws_pkg::hmws_sample_s target = '0;
  hmws_pkg::hmws_sample_s field;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int n;
  always #5 mclk = ~mclk;
  hmws_top DUT
  (
    .I_MCLK(mclk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .I_FIELD_X(field.x), .I_FIELD_Y(field.y), .I_FIELD_Z(field.z),
    .I_ANGLE(field.angle), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_INT(irq), .O_CONV_ACTIVE(conv)
  );
  hmws_field_src u_src
  (
    .i_clk(mclk), .i_conv(conv), .i_target(target), .o_sample(field)
  );
  // ===========================================================
  // tasks
  task complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, string what);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      error_cnt++;
    end
  endtask
  // one classic cycle; waits for ack rather than assuming a latency
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rdv = rdat;
    chk({31'h0, ack}, 32'h1, "bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  // count sampled cycles for which the pass flag holds one level
  task span(input logic lvl, output int c);
    c = 0;
    while (conv === lvl && c < 60000)
    begin
      @(posedge mclk);
      c++;
    end
  endtask
  // hang guard, just above the ~98k cycles the tests need
  always @(posedge mclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 99000)
    begin
      $display("[FAIL] %0t run too long", $time);
      error_cnt++;
      complete_run();
    end
  end
  // ===========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].adr, 32'h0);
      chk(rdv, rows[i].rd, "register access");
    end
    $display("test registers done");
    // second reset in mid-run must bring every register back to zero
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wb(1'b0, rows[i].adr, 32'h0);
      chk(rdv, 32'h0, "reset value");
    end
    chk({30'h0, irq, conv}, 32'h0, "quiet after reset");
    $display("test reset done");
    // wake-up sleep, x only, fixed reference, standby 100 us
    target.x <= 16'h0100;
    wb(1'b1, `HMWS_ADR_ITEMS, 32'h00000001);
    wb(1'b1, `HMWS_ADR_TIMING, 32'h00010000);
    wb(1'b1, `HMWS_ADR_THRESH, 32'h00000800);
    wb(1'b1, `HMWS_ADR_MASK, 32'h00000001);
    wb(1'b1, `HMWS_ADR_CTRL, 32'h00000002);
    span(1'b0, n);
    span(1'b1, n);
    chk(n, 32'h6aa4, "first pass 27300 cycles");
    target.x <= 16'h0901;
    span(1'b0, n);
    chk(n, 32'h2710, "standby 10000 cycles");
    chk({31'h0, irq}, 32'h0, "reference pass no wake");
    span(1'b1, n);
    chk(n, 32'h6aa4, "second pass 27300 cycles");
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "threshold wake");
    wb(1'b0, `HMWS_ADR_DATX, 32'h0);
    chk({16'h0, rdv[15:0]}, 32'h0901, "x result");
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "data read clears");
    wb(1'b1, `HMWS_ADR_CTRL, 32'h00000000);
    $display("test wake done");
    // data read dropped the wake bit; done bit stays until status read
    wb(1'b0, `HMWS_ADR_STATUS, 32'h0);
    chk(rdv, 32'h4, "wake bit gone, done kept");
    // single pass, no items: overhead alone keeps the run short
    wb(1'b1, `HMWS_ADR_ITEMS, 32'h00000000);
    wb(1'b1, `HMWS_ADR_TIMING, 32'h00000000);
    wb(1'b1, `HMWS_ADR_CTRL, 32'h00000003);
    span(1'b0, n);
    span(1'b1, n);
    chk(n, 32'h8020, "single pass 32800 cycles");
    repeat (5) @(posedge mclk);
    chk({31'h0, conv}, 32'h0, "no second pass");
    wb(1'b0, `HMWS_ADR_CTRL, 32'h0);
    chk(rdv, 32'h0, "mode back to idle");
    wb(1'b0, `HMWS_ADR_STATUS, 32'h0);
    chk(rdv, 32'h4, "pass done only");
    wb(1'b0, `HMWS_ADR_STATUS, 32'h0);
    chk(rdv, 32'h0, "status cleared by read");
    $display("test single done");
    complete_run();
  end
endmodule // testbench
